/* shared/rss_pkg.sv */
// Functional notes
// - five reset sources; power-on and hard reset clear everything, relatch straps.
// - soft reset clears bus, MAC layer, MAC; reloads EEPROM; spares PLL, PHY, exempt.
// - power-on holds internal reset for about 22 ms.
// - ready reads 0 during power-on reset, then sets; configuration allowed after.
// - hard reset input low starts full reset; ready 0 until it completes.
// - hard reset input is pulled up, inactive when unconnected.
// - after wake test write, ready sets within 2 ms.
// - hardware config bit 0 starts soft reset, self clears after about 2 us.
// - power control bit 10 resets PHY only, self clears after about 100 us.
// - PHY basic control bit 15 resets PHY only, self clears when done.
// - after full or soft reset, probe EEPROM while holding busy indication.
// - in sleep, any write to wake test register wakes the device.
package rss_pkg;
   localparam int CLK_MHZ = 100;
   localparam int TMR_W = 22;
   localparam int POR_TIME_MS = 22;
   localparam int POR_CYCLES = POR_TIME_MS * 1000 * CLK_MHZ;
   localparam int HARD_TIME_NS = 2000;
   localparam int HARD_CYCLES = (HARD_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int SOFT_TIME_NS = 2000;
   localparam int SOFT_CYCLES = (SOFT_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int PHY_TIME_US = 100;
   localparam int PHY_CYCLES = PHY_TIME_US * CLK_MHZ;
   localparam int WAKE_TIME_MS = 2;
   localparam int WAKE_CYCLES = WAKE_TIME_MS * 1000 * CLK_MHZ;
   localparam int PROBE_TIME_US = 10;
   localparam int PROBE_CYCLES = PROBE_TIME_US * CLK_MHZ;
   localparam int STRAP_W = 4;
   localparam logic [7:0] HARDWARE_CONFIG_OFS = 8'h00;
   localparam logic [7:0] PMC_OFS = 8'h04;
   localparam logic [7:0] WAKE_TEST_OFS = 8'h08;
   localparam logic [7:0] EEPROM_CMD_OFS = 8'h0C;
   localparam logic [7:0] PHY_BCR_OFS = 8'h10;
   localparam logic [7:0] RST_STAT_OFS = 8'h14;
   localparam int SOFT_RESET_POS = 0;
   localparam int GEN_CFG_LSB = 4;
   localparam int EXEMPT_LSB = 16;
   localparam int READY_POS = 0;
   localparam int PHY_RST_POS = 10;
   localparam int PM_MODE_LSB = 12;
   localparam int EEPROM_FOUND_POS = 8;
   localparam int EEPROM_BUSY_POS = 31;
   localparam int PHY_BCR_RST_POS = 15;
   localparam int DOMAIN_LSB = 8;
   localparam logic [3:0] GEN_CFG_RST = 4'h0;
   localparam logic [7:0] EXEMPT_RST = 8'h00;
   localparam logic [1:0] PM_MODE_RST = 2'h0;
   // arbitrary fixed pattern, lets software check bus wiring
   localparam logic [31:0] WAKE_TEST_VALUE = 32'hA5C3_0F96;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } rss_wb_req_t;

   typedef struct packed {
      logic pll;
      logic host_bus;
      logic exempt;
      logic mac_if;
      logic mac;
      logic phy;
   } rss_domain_t;

   typedef enum logic [2:0] {
      SEQ_FULL_HOLD,
      SEQ_FULL_TIMING,
      SEQ_RUN,
      SEQ_SOFT,
      SEQ_SLEEP,
      SEQ_WAKE
   } rss_seq_t;
endpackage : rss_pkg

/* hdl/rss_countdown.sv */
`timescale 1ns/1ps
module rss_countdown
(
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [rss_pkg::TMR_W-1:0] value,
   output logic busy,
   output logic done
);
   import rss_pkg::*;
   logic [TMR_W-1:0] count_reg;
   logic done_reg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         count_reg <= '0;
      else if (load)
         count_reg <= value;
      else if (count_reg != '0)
         count_reg <= count_reg - 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         done_reg <= 1'b0;
      else
         done_reg <= (count_reg == TMR_W'(1)) & ~load;
   end

   assign busy = (count_reg != '0);
   assign done = done_reg;
endmodule : rss_countdown

/* hdl/rss_eeprom_probe.sv */
`timescale 1ns/1ps
module rss_eeprom_probe
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic detect,
   output logic busy,
   output logic found
);
   import rss_pkg::*;
   logic [TMR_W-1:0] cnt_reg;
   logic busy_reg;
   logic found_reg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_reg <= '0;
      else if (start)
         cnt_reg <= TMR_W'(PROBE_CYCLES);
      else if (cnt_reg != '0)
         cnt_reg <= cnt_reg - 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         busy_reg <= 1'b0;
      else if (start)
         busy_reg <= 1'b1;
      else if (cnt_reg == TMR_W'(1))
         busy_reg <= 1'b0;
   end

   // presence sampled at the end of the probe window only
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         found_reg <= 1'b0;
      else if (busy_reg && cnt_reg == TMR_W'(1))
         found_reg <= detect;
   end

   assign busy = busy_reg;
   assign found = found_reg;
endmodule : rss_eeprom_probe

/* hdl/rss_top.sv */
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module rss_top
#(
   parameter int POR_CYCLES = rss_pkg::POR_CYCLES,
   parameter int PHY_CYCLES = rss_pkg::PHY_CYCLES,
   parameter int WAKE_CYCLES = rss_pkg::WAKE_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hard_reset_in_n,
   input wire logic [rss_pkg::STRAP_W-1:0] strap_in,
   input wire logic eeprom_detect,
   input wire rss_pkg::rss_wb_req_t wb_req,
   output logic wb_ack,
   output logic [31:0] wb_rdata,
   output rss_pkg::rss_domain_t domain_reset,
   output logic ready,
   output logic eeprom_busy,
   output logic [rss_pkg::STRAP_W-1:0] strap_latched
);
   import rss_pkg::*;

   function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
      reg_hit = (adr[7:2] == ofs[7:2]);
   endfunction : reg_hit

   function automatic logic lane_on(input logic [3:0] sel, input int pos);
      logic [1:0] lane;
      lane = 2'(pos / 8);
      lane_on = sel[lane];
   endfunction : lane_on

   rss_seq_t seq_reg;
   rss_seq_t seq_next;
   logic por_pending_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   rss_domain_t domain_reg;
   rss_domain_t domain_next;
   logic ready_reg;
   logic eeprom_busy_reg;
   logic [STRAP_W-1:0] strap_reg;
   logic [3:0] gen_cfg_reg;
   logic [7:0] exempt_reg;
   logic [1:0] pm_mode_reg;
   logic phy_pmc_reg;
   logic phy_bcr_reg;

   logic hard_low;
   logic req;
   logic wr;
   logic run_wr;
   logic full_act;
   logic soft_go;
   logic sleep_go;
   logic wake_go;
   logic phy_pmc_go;
   logic phy_bcr_go;
   logic full_load;
   logic soft_load;
   logic wake_load;
   logic phy_load;
   logic [TMR_W-1:0] full_value;
   logic full_busy;
   logic full_done;
   logic soft_busy;
   logic soft_done;
   logic phy_busy;
   logic phy_done;
   logic wake_busy;
   logic wake_done;
   logic probe_start;
   logic probe_busy;
   logic probe_found;

   // pad pull-up keeps an open input high, so only a real low resets
   assign hard_low = ~hard_reset_in_n;

   assign req = wb_req.cyc & wb_req.stb & ~ack_reg;
   assign wr = req & wb_req.we;
   // host bus is in reset or asleep outside run: writes have no effect, except the wake test write in sleep
   assign run_wr = wr & (seq_reg == SEQ_RUN) & ~hard_low;
   assign full_act = (seq_reg == SEQ_FULL_HOLD) || (seq_reg == SEQ_FULL_TIMING);

   assign soft_go = run_wr & reg_hit(wb_req.adr, HARDWARE_CONFIG_OFS)
      & lane_on(wb_req.sel, SOFT_RESET_POS) & wb_req.dat[SOFT_RESET_POS];
   assign sleep_go = run_wr & reg_hit(wb_req.adr, PMC_OFS)
      & lane_on(wb_req.sel, PM_MODE_LSB)
      & (wb_req.dat[PM_MODE_LSB+:2] != 2'h0);
   // any data, any lanes: the write itself is the wake request
   assign wake_go = wr & reg_hit(wb_req.adr, WAKE_TEST_OFS)
      & (seq_reg == SEQ_SLEEP) & ~hard_low;
   assign phy_pmc_go = run_wr & reg_hit(wb_req.adr, PMC_OFS)
      & lane_on(wb_req.sel, PHY_RST_POS) & wb_req.dat[PHY_RST_POS];
   assign phy_bcr_go = run_wr & reg_hit(wb_req.adr, PHY_BCR_OFS)
      & lane_on(wb_req.sel, PHY_BCR_RST_POS) & wb_req.dat[PHY_BCR_RST_POS];

   // the full timer starts only once the asserting source lets go
   assign full_load = (seq_reg == SEQ_FULL_HOLD) & ~hard_low;
   assign full_value = por_pending_reg ? TMR_W'(POR_CYCLES)
      : TMR_W'(HARD_CYCLES);
   assign soft_load = soft_go;
   assign wake_load = wake_go;
   // a second request during a running PHY reset is absorbed, not restarted
   assign phy_load = (phy_pmc_go | phy_bcr_go) & ~phy_busy;
   assign probe_start = (full_done & (seq_reg == SEQ_FULL_TIMING))
      | (soft_done & (seq_reg == SEQ_SOFT));

   rss_countdown u_full_tmr
   (
      .clk(clk),
      .rst(rst),
      .load(full_load),
      .value(full_value),
      .busy(full_busy),
      .done(full_done)
   );

   rss_countdown u_soft_tmr
   (
      .clk(clk),
      .rst(rst),
      .load(soft_load),
      .value(TMR_W'(SOFT_CYCLES)),
      .busy(soft_busy),
      .done(soft_done)
   );

   rss_countdown u_phy_tmr
   (
      .clk(clk),
      .rst(rst),
      .load(phy_load),
      .value(TMR_W'(PHY_CYCLES)),
      .busy(phy_busy),
      .done(phy_done)
   );

   rss_countdown u_wake_tmr
   (
      .clk(clk),
      .rst(rst),
      .load(wake_load),
      .value(TMR_W'(WAKE_CYCLES)),
      .busy(wake_busy),
      .done(wake_done)
   );

   rss_eeprom_probe u_probe
   (
      .clk(clk),
      .rst(rst),
      .start(probe_start),
      .detect(eeprom_detect),
      .busy(probe_busy),
      .found(probe_found)
   );

   always_comb
   begin
      seq_next = seq_reg;
      case (seq_reg)
         SEQ_FULL_HOLD:
            if (!hard_low)
               seq_next = SEQ_FULL_TIMING;
         SEQ_FULL_TIMING:
            if (full_done)
               seq_next = SEQ_RUN;
         SEQ_RUN:
            if (soft_go)
               seq_next = SEQ_SOFT;
            else if (sleep_go)
               seq_next = SEQ_SLEEP;
         SEQ_SOFT:
            if (soft_done)
               seq_next = SEQ_RUN;
         SEQ_SLEEP:
            if (wake_go)
               seq_next = SEQ_WAKE;
         SEQ_WAKE:
            if (wake_done)
               seq_next = SEQ_RUN;
         default:
            seq_next = SEQ_FULL_HOLD;
      endcase
      if (hard_low)
         seq_next = SEQ_FULL_HOLD;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         seq_reg <= SEQ_FULL_HOLD;
      else
         seq_reg <= seq_next;
   end

   // first full sequence after power-up uses the long power-on time
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         por_pending_reg <= 1'b1;
      else if (full_load)
         por_pending_reg <= 1'b0;
   end

   // ready follows entry into run; cleared by full or soft reset or sleep, not by PHY reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ready_reg <= 1'b0;
      else
         ready_reg <= (seq_next == SEQ_RUN);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         strap_reg <= '0;
      else if (full_load)
         strap_reg <= strap_in;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         gen_cfg_reg <= GEN_CFG_RST;
      else if (full_act || seq_reg == SEQ_SOFT)
         gen_cfg_reg <= GEN_CFG_RST;
      else if (run_wr && reg_hit(wb_req.adr, HARDWARE_CONFIG_OFS)
               && lane_on(wb_req.sel, GEN_CFG_LSB))
         gen_cfg_reg <= wb_req.dat[GEN_CFG_LSB+:4];
   end

   // exempt bits survive a soft reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         exempt_reg <= EXEMPT_RST;
      else if (full_act)
         exempt_reg <= EXEMPT_RST;
      else if (run_wr && reg_hit(wb_req.adr, HARDWARE_CONFIG_OFS)
               && lane_on(wb_req.sel, EXEMPT_LSB))
         exempt_reg <= wb_req.dat[EXEMPT_LSB+:8];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pm_mode_reg <= PM_MODE_RST;
      else if (full_act || wake_load)
         pm_mode_reg <= PM_MODE_RST;
      else if (sleep_go && !soft_go)
         pm_mode_reg <= wb_req.dat[PM_MODE_LSB+:2];
   end

   // set wins: a new request in the cycle of a done restarts the bit
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         phy_pmc_reg <= 1'b0;
      else if (full_act)
         phy_pmc_reg <= 1'b0;
      else if (phy_load && phy_pmc_go)
         phy_pmc_reg <= 1'b1;
      else if (phy_done)
         phy_pmc_reg <= 1'b0;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         phy_bcr_reg <= 1'b0;
      else if (full_act)
         phy_bcr_reg <= 1'b0;
      else if (phy_load && phy_bcr_go)
         phy_bcr_reg <= 1'b1;
      else if (phy_done)
         phy_bcr_reg <= 1'b0;
   end

   always_comb
   begin
      domain_next.pll = full_act;
      domain_next.host_bus = full_act | (seq_reg == SEQ_SOFT);
      domain_next.exempt = full_act;
      domain_next.mac_if = full_act | (seq_reg == SEQ_SOFT);
      domain_next.mac = full_act | (seq_reg == SEQ_SOFT);
      domain_next.phy = full_act | phy_busy | phy_load;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         domain_reg <= '1;
      else
         domain_reg <= domain_next;
   end

   // busy from the moment a reset starts, so it never reads clear early
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         eeprom_busy_reg <= 1'b1;
      else
         eeprom_busy_reg <= full_act | (seq_reg == SEQ_SOFT)
            | probe_start | probe_busy;
   end

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (reg_hit(wb_req.adr, HARDWARE_CONFIG_OFS))
      begin
         rdata_next[SOFT_RESET_POS] = (seq_reg == SEQ_SOFT);
         rdata_next[GEN_CFG_LSB+:4] = gen_cfg_reg;
         rdata_next[EXEMPT_LSB+:8] = exempt_reg;
      end
      else if (reg_hit(wb_req.adr, PMC_OFS))
      begin
         rdata_next[READY_POS] = ready_reg;
         rdata_next[PHY_RST_POS] = phy_pmc_reg;
         rdata_next[PM_MODE_LSB+:2] = pm_mode_reg;
      end
      else if (reg_hit(wb_req.adr, WAKE_TEST_OFS))
         rdata_next = WAKE_TEST_VALUE;
      else if (reg_hit(wb_req.adr, EEPROM_CMD_OFS))
      begin
         rdata_next[EEPROM_BUSY_POS] = eeprom_busy_reg;
         rdata_next[EEPROM_FOUND_POS] = probe_found;
      end
      else if (reg_hit(wb_req.adr, PHY_BCR_OFS))
         rdata_next[PHY_BCR_RST_POS] = phy_bcr_reg;
      else if (reg_hit(wb_req.adr, RST_STAT_OFS))
      begin
         rdata_next[STRAP_W-1:0] = strap_reg;
         rdata_next[DOMAIN_LSB+:6] = domain_reg;
      end
   end

   // ack answers every address, even during reset, so ready stays pollable
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ack_reg <= 1'b0;
      else
         ack_reg <= req;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata_reg <= 32'h0000_0000;
      else if (req && !wb_req.we)
         rdata_reg <= rdata_next;
   end

   assign wb_ack = ack_reg;
   assign wb_rdata = rdata_reg;
   assign domain_reset = domain_reg;
   assign ready = ready_reg;
   assign eeprom_busy = eeprom_busy_reg;
   assign strap_latched = strap_reg;
endmodule : rss_top

/* tb/rss_top_checker.sv */
`timescale 1ns/1ps
module rss_top_checker
import rss_pkg::*;
#(
   parameter int POR_CYCLES = 50,
   parameter int PHY_CYCLES = 30,
   parameter int WAKE_CYCLES = 40
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hard_reset_in_n,
   input wire logic [rss_pkg::STRAP_W-1:0] strap_in,
   input wire logic eeprom_detect,
   input wire rss_pkg::rss_wb_req_t wb_req,
   input wire logic wb_ack,
   input wire logic [31:0] wb_rdata,
   input wire rss_pkg::rss_domain_t domain_reset,
   input wire logic ready,
   input wire logic eeprom_busy,
   input wire logic [rss_pkg::STRAP_W-1:0] strap_latched
);
   // recovery timer plus done and ready register slack
   localparam int HR_LO = 196;
   localparam int HR_HI = 212;
   int phy_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // counts phy-only reset cycles; a full reset clears it
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         phy_cnt <= 0;
      else if (domain_reset.pll || !domain_reset.phy)
         phy_cnt <= 0;
      else
         phy_cnt <= phy_cnt + 1;
   end

   sequence s_pin_low;
      !hard_reset_in_n;
   endsequence
   sequence s_all_held;
      domain_reset == 6'h3F;
   endsequence

   a_ack_single: assert property (wb_ack |=> !wb_ack)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack)
      else $error("request not acked");
   a_ack_cause: assert property (wb_ack |-> $past(wb_req.cyc && wb_req.stb))
      else $error("ack without request");
   a_hard_full: assert property (s_pin_low |-> ##1 !ready ##1 s_all_held)
      else $error("hard reset did not clear all");
   a_hard_timing: assert property ($rose(hard_reset_in_n) |-> ##[HR_LO:HR_HI] $rose(ready))
      else $error("ready not set on time after hard reset");
   a_soft_spares: assert property (domain_reset.host_bus && !domain_reset.pll
      |-> domain_reset.mac_if && domain_reset.mac && !domain_reset.exempt)
      else $error("soft reset domains wrong");
   a_phy_length: assert property ($fell(domain_reset.phy) && !$past(domain_reset.pll)
      |-> phy_cnt >= PHY_CYCLES - 1 && phy_cnt <= PHY_CYCLES + 1)
      else $error("phy reset length wrong");
   a_probe_busy: assert property ($fell(domain_reset.mac) |-> ##[0:3] eeprom_busy)
      else $error("no eeprom probe after reset");
   a_strap_latch: assert property ($fell(domain_reset.pll) |-> strap_latched == strap_in)
      else $error("straps not relatched");
endmodule : rss_top_checker

/* tb/rss_host_model.sv */
`timescale 1ns/1ps
module rss_host_model
import rss_pkg::*;
(
   input wire logic clk,
   input wire logic wb_ack,
   input wire logic [31:0] wb_rdata,
   output rss_pkg::rss_wb_req_t wb_req
);
   initial wb_req = '0;

   task xfer(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      wb_req <= {1'b1, 1'b1, we, a, 4'hF, wd};
      @(posedge clk);
      while (wb_ack !== 1'b1)
         @(posedge clk);
      rd = wb_rdata;
      wb_req <= '0;
      @(posedge clk);
   endtask : xfer

   task wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] dummy;
      xfer(1'b1, a, wd, dummy);
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] rdv);
      xfer(1'b0, a, 32'h0000_0000, rdv);
   endtask : rd

   // reads only until ready, and gives up after a bounded count
   task poll(output logic [31:0] rdv);
      int k;
      k = 0;
      rdv = 32'h0000_0000;
      while (rdv[READY_POS] !== 1'b1 && k < 2000)
      begin
         rd(PMC_OFS, rdv);
         k++;
      end
   endtask : poll
endmodule : rss_host_model

/* tb/rss_top_tb.sv */
`timescale 1ns/1ps
module rss_top_tb;
   import rss_pkg::*;
   localparam int POR_T = 50;
   localparam int PHY_T = 30;
   localparam int WAKE_T = 40;
   // shortest pin pulse we promise to give
   localparam int HOLD_N = 10;
   logic clk, rst, hard_reset_in_n, eeprom_detect, wb_ack, ready, eeprom_busy;
   logic [STRAP_W-1:0] strap_in, strap_latched;
   logic [31:0] wb_rdata, d, v;
   logic [7:0] a;
   rss_wb_req_t wb_req;
   rss_domain_t domain_reset;
   int n_fail, comparisons, n, t0;
   int cyc_n = 0;

   rss_top #(.POR_CYCLES(POR_T), .PHY_CYCLES(PHY_T), .WAKE_CYCLES(WAKE_T)) rss_top_inst (
      .clk, .rst, .hard_reset_in_n, .strap_in, .eeprom_detect, .wb_req, .wb_ack,
      .wb_rdata, .domain_reset, .ready, .eeprom_busy, .strap_latched);
   rss_host_model rss_host_model_inst (.clk, .wb_ack, .wb_rdata, .wb_req);

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc_n <= cyc_n + 1;

   task chk(input bit ok, input string m);
      comparisons++;
      if (!ok)
      begin
         n_fail++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk

   task final_report;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   task wait_rdy;
      n = 0;
      while (ready !== 1'b1 && n < 5000)
      begin
         @(posedge clk);
         n++;
      end
   endtask : wait_rdy

   task wait_ee;
      n = 0;
      while (eeprom_busy !== 1'b0 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
   endtask : wait_ee

   task t_por;
      t0 = cyc_n;
      rss_host_model_inst.rd(PMC_OFS, d);
      chk(d[READY_POS] === 1'b0, "ready read high during power-on");
      rss_host_model_inst.wr(HARDWARE_CONFIG_OFS, 32'h0000_00F0);
      wait_rdy;
      chk(cyc_n - t0 >= POR_T && cyc_n - t0 <= POR_T + 8, "power-on length");
      chk(strap_latched === 4'hA, "straps at power-on");
      rss_host_model_inst.rd(HARDWARE_CONFIG_OFS, d);
      chk(d[7:4] === GEN_CFG_RST, "write before ready took effect");
      wait_ee;
      rss_host_model_inst.rd(EEPROM_CMD_OFS, d);
      chk(d[31] === 1'b0 && d[8] === 1'b1, "probe result after power-on");
      $display("t_por done");
   endtask : t_por

   task t_hard;
      rss_host_model_inst.wr(HARDWARE_CONFIG_OFS, 32'h00AA_0050);
      hard_reset_in_n <= 1'b0;
      strap_in <= 4'h5;
      eeprom_detect <= 1'b0;
      repeat (3) @(posedge clk);
      chk(ready === 1'b0 && domain_reset === 6'h3F, "pin low not full reset");
      repeat (HOLD_N) @(posedge clk);
      hard_reset_in_n <= 1'b1;
      t0 = cyc_n;
      wait_rdy;
      chk(cyc_n - t0 >= HARD_CYCLES && cyc_n - t0 <= HARD_CYCLES + 8, "hard length");
      chk(strap_latched === 4'h5, "straps not relatched");
      rss_host_model_inst.rd(RST_STAT_OFS, d);
      chk(d[3:0] === 4'h5 && d[13:8] === 6'h00, "status after hard");
      rss_host_model_inst.rd(HARDWARE_CONFIG_OFS, d);
      chk(d[23:16] === EXEMPT_RST && d[7:4] === GEN_CFG_RST, "hard reset kept bits");
      wait_ee;
      rss_host_model_inst.rd(EEPROM_CMD_OFS, d);
      chk(d[31] === 1'b0 && d[8] === 1'b0, "probe result after hard");
      $display("t_hard done");
   endtask : t_hard

   task t_soft;
      rss_host_model_inst.wr(HARDWARE_CONFIG_OFS, 32'h005A_0030);
      t0 = cyc_n;
      rss_host_model_inst.wr(HARDWARE_CONFIG_OFS, 32'h005A_0031);
      chk(ready === 1'b0 && domain_reset === 6'h16, "soft reset domains");
      rss_host_model_inst.rd(HARDWARE_CONFIG_OFS, d);
      chk(d[SOFT_RESET_POS] === 1'b1, "soft bit not set");
      wait_rdy;
      chk(cyc_n - t0 >= SOFT_CYCLES && cyc_n - t0 <= SOFT_CYCLES + 8, "soft length");
      rss_host_model_inst.rd(HARDWARE_CONFIG_OFS, d);
      chk(d[0] === 1'b0 && d[23:16] === 8'h5A && d[7:4] === GEN_CFG_RST, "soft bits");
      chk(strap_latched === 4'h5 && eeprom_busy === 1'b1, "soft straps or probe");
      wait_ee;
      chk(eeprom_busy === 1'b0, "soft probe stuck");
      $display("t_soft done");
   endtask : t_soft

   task t_phy;
      for (int i = 0; i < 2; i++)
      begin
         a = (i == 0) ? PMC_OFS : PHY_BCR_OFS;
         v = (i == 0) ? 32'h0000_0400 : 32'h0000_8000;
         t0 = cyc_n;
         rss_host_model_inst.wr(a, v);
         chk(domain_reset === 6'h01 && ready === 1'b1, "phy reset domains");
         rss_host_model_inst.rd(a, d);
         chk((d & v) === v, "phy bit not set");
         while (domain_reset.phy !== 1'b0 && cyc_n - t0 < 500)
            @(posedge clk);
         chk(cyc_n - t0 >= PHY_T && cyc_n - t0 <= PHY_T + 6, "phy length");
         rss_host_model_inst.rd(a, d);
         chk((d & v) === 32'h0000_0000, "phy bit not cleared");
      end
      $display("t_phy done");
   endtask : t_phy

   task t_sleep;
      rss_host_model_inst.wr(PMC_OFS, 32'h0000_1000);
      chk(ready === 1'b0, "sleep kept ready");
      t0 = cyc_n;
      rss_host_model_inst.wr(WAKE_TEST_OFS, 32'h0000_0000);
      rss_host_model_inst.poll(d);
      chk(d[READY_POS] === 1'b1 && cyc_n - t0 <= WAKE_T + 10, "wake too slow");
      rss_host_model_inst.rd(PMC_OFS, d);
      chk(d[13:12] === PM_MODE_RST, "pm mode not reset");
      rss_host_model_inst.rd(WAKE_TEST_OFS, d);
      chk(d === WAKE_TEST_VALUE, "wake test pattern");
      rss_host_model_inst.rd(8'h40, d);
      chk(d === 32'h0000_0000, "unmapped read");
      $display("t_sleep done");
   endtask : t_sleep

   initial
   begin
      rst = 1'b1;
      hard_reset_in_n = 1'b1;
      strap_in = 4'hA;
      eeprom_detect = 1'b1;
      n_fail = 0;
      comparisons = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_por;
      t_hard;
      t_soft;
      t_phy;
      t_sleep;
      final_report;
   end

   // all tests need well under 8000 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report;
   end
endmodule : rss_top_tb

bind rss_top rss_top_checker #(.POR_CYCLES(POR_CYCLES), .PHY_CYCLES(PHY_CYCLES),
   .WAKE_CYCLES(WAKE_CYCLES)) rss_top_checker_inst (.clk, .rst, .hard_reset_in_n,
   .strap_in, .eeprom_detect, .wb_req, .wb_ack, .wb_rdata, .domain_reset, .ready,
   .eeprom_busy, .strap_latched);
